// ===== logic/mmel_pkg.sv
package mmel_pkg;

  // ==================================================
  // register bus
  localparam int REG_ADDR_W = 4;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CONTROL = 4'h4;
  localparam logic [3:0] REG_TRIM = 4'h8;

  // ==================================================
  // field positions
  localparam int CTL_IRQ_ENABLE = 0;
  localparam int CTL_RESET_PIN_ENABLE = 1;
  localparam int CTL_OSC_PIN_ENABLE = 2;
  localparam int TRIM_PROGRAMMED = 8;
  localparam int ST_MODE_LO = 0;
  localparam int ST_INTERNAL_RESET = 4;
  localparam int ST_SEC_COUNT_LO = 8;
  localparam int ST_BREAK_SENT = 12;
  localparam int ST_TEST_VOLTAGE = 13;
  localparam int ST_POR_SESSION = 14;

  // ==================================================
  // reset values
  localparam logic [2:0] CONTROL_RESET = 3'h0;
  localparam logic [7:0] TRIM_RESET = 8'h80;

  // ==================================================
  // timing and link figures
  localparam int BIT_PERIOD_W = 9;
  localparam logic [8:0] BIT_PERIOD_EXT = 9'h100;
  localparam logic [8:0] BIT_PERIOD_INT = 9'h14f;
  localparam logic [3:0] BREAK_BITS = 4'ha;
  localparam logic [3:0] SECURITY_BYTES = 4'h8;
  localparam int RESET_HOLD_CYCLES = 64;

  // ==================================================
  // vector pages
  localparam logic [7:0] BLANK_BYTE = 8'hff;
  localparam logic [7:0] VECTOR_PAGE_USER = 8'hff;
  localparam logic [7:0] VECTOR_PAGE_MONITOR = 8'hfe;

  // ==================================================
  // types
  typedef enum logic [3:0] {
    MODE_USER = 4'b0001,
    MODE_NORMAL = 4'b0010,
    MODE_FORCED_EXT = 4'b0100,
    MODE_FORCED_INT = 4'b1000
  } mmel_mode_type;

  typedef enum logic [1:0] {
    RS_HOLD = 2'b01,
    RS_RUN = 2'b10
  } mmel_rst_state_type;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } mmel_rx_state_type;

endpackage

// ===== logic/mmel_link_if.sv
`timescale 1ns/100ps
interface mmel_link_if;
  logic enable;
  logic [8:0] bit_period;
  logic rx_level;
  logic tx_drive_low;
  logic [3:0] sec_count;
  logic break_sent;

  modport ctrl (
    output enable,
    output bit_period,
    output rx_level,
    input tx_drive_low,
    input sec_count,
    input break_sent
  );

  modport engine (
    input enable,
    input bit_period,
    input rx_level,
    output tx_drive_low,
    output sec_count,
    output break_sent
  );
endinterface

// ===== logic/mmel_serial_engine.sv
`timescale 1ns/100ps
module mmel_serial_engine (
  input wire logic mclk,
  input wire logic reset,
  mmel_link_if.engine link
);

  // ==================================================
  // receive framing
  mmel_pkg::mmel_rx_state_type rx_state;
  logic [8:0] rx_tick;
  logic [2:0] rx_bit;
  logic [8:0] half_period;
  logic byte_done;

  assign half_period = {1'b0, link.bit_period[8:1]};

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rx_state <= mmel_pkg::RX_IDLE;
      rx_tick <= 9'h000;
      rx_bit <= 3'h0;
      byte_done <= 1'b0;
    end else begin
      byte_done <= 1'b0;
      if (!link.enable) begin
        rx_state <= mmel_pkg::RX_IDLE;
        rx_tick <= 9'h000;
      end else begin
        unique case (rx_state)
          mmel_pkg::RX_IDLE: begin
            rx_tick <= 9'h001;
            if (!link.rx_level) begin
              rx_state <= mmel_pkg::RX_START;
            end
          end
          mmel_pkg::RX_START: begin
            rx_tick <= rx_tick + 9'h001;
            if (rx_tick >= half_period) begin
              rx_tick <= 9'h001;
              rx_bit <= 3'h0;
              rx_state <= link.rx_level ? mmel_pkg::RX_IDLE : mmel_pkg::RX_DATA;
            end
          end
          mmel_pkg::RX_DATA: begin
            rx_tick <= rx_tick + 9'h001;
            if (rx_tick >= link.bit_period) begin
              rx_tick <= 9'h001;
              rx_bit <= rx_bit + 3'h1;
              if (rx_bit == 3'h7) begin
                rx_state <= mmel_pkg::RX_STOP;
              end
            end
          end
          mmel_pkg::RX_STOP: begin
            rx_tick <= rx_tick + 9'h001;
            if (rx_tick >= link.bit_period) begin
              byte_done <= 1'b1;
              rx_state <= mmel_pkg::RX_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ==================================================
  // security byte count
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      link.sec_count <= 4'h0;
    end else if (!link.enable) begin
      link.sec_count <= 4'h0;
    end else if (byte_done && link.sec_count != mmel_pkg::SECURITY_BYTES) begin
      link.sec_count <= link.sec_count + 4'h1;
    end
  end

  // ==================================================
  // break transmit
  logic [8:0] tx_tick;
  logic [3:0] tx_bits;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      link.tx_drive_low <= 1'b0;
      link.break_sent <= 1'b0;
      tx_tick <= 9'h000;
      tx_bits <= 4'h0;
    end else if (!link.enable) begin
      link.tx_drive_low <= 1'b0;
      link.break_sent <= 1'b0;
      tx_tick <= 9'h000;
      tx_bits <= 4'h0;
    end else if (link.tx_drive_low) begin
      tx_tick <= tx_tick + 9'h001;
      if (tx_tick >= link.bit_period) begin
        tx_tick <= 9'h001;
        tx_bits <= tx_bits + 4'h1;
        if (tx_bits == mmel_pkg::BREAK_BITS - 4'h1) begin
          link.tx_drive_low <= 1'b0;
          link.break_sent <= 1'b1;
        end
      end
    end else if (!link.break_sent && link.sec_count == mmel_pkg::SECURITY_BYTES
                 && rx_state == mmel_pkg::RX_IDLE) begin
      link.tx_drive_low <= 1'b1;
      tx_tick <= 9'h001;
      tx_bits <= 4'h0;
    end
  end

endmodule

// ===== logic/mmel_monitor_entry.sv
// Contract
// - all monitor traffic uses one wired-or serial pin with pullup
// - interrupt pin low at reset selects trimmed internal oscillator
// - internal oscillator entry needs a blank reset vector
// - monitor entry only after power-on reset with permitted pin set
// - mode latched at internal reset release; normal needs straps one, zero
// - bit period 256 clocks external, 335 clocks internal
// - after security bytes device sends ten zero bits break
// - normal mode: alternate pin functions only while test voltage applied; code also enables them from the control pin enable bits
// - after test voltage removed, irq sampling follows enable bit
// - normal entry: watchdog off while test voltage stays
// - blank vector entry passes one extra reset cycle
// - blank vector entry: watchdog always disabled
// - blank reset vector fetch forces reset into forced monitor mode
// - forced mode: plain inputs except serial and maybe oscillator pin
// - monitor mode: port bit two reads zero, irq sampling enabled; code: normal mode without test voltage follows the enable bit
// - in forced mode any non power-on reset returns to forced mode
// - monitor mode fetches vectors from fe page
// - blank vector monitor mode exits only by power-on reset
// - nrz frames with equal transmit and receive rates
`timescale 1ns/100ps
module mmel_monitor_entry #(
  parameter int HOLD_CYCLES = mmel_pkg::RESET_HOLD_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic irq_pin,
  input wire logic high_test_voltage,
  input wire logic mode_strap_zero,
  input wire logic mode_strap_one,
  input wire logic reset_pin_n,
  input wire logic monitor_serial_pin_in,
  input wire logic vec_fetch_valid,
  input wire logic vec_fetch_high,
  input wire logic [7:0] vec_fetch_data,
  output logic monitor_serial_pin_out,
  output logic monitor_serial_pin_oe,
  output logic internal_reset,
  output logic monitor_active,
  output logic forced_mode,
  output logic use_internal_osc,
  output logic apply_trim,
  output logic [7:0] oscillator_trim_value,
  output logic watchdog_disable,
  output logic [7:0] vector_page,
  output logic reset_alt_enable,
  output logic osc_input_alt_enable,
  output logic porta_bit2_zero,
  output logic irq_sample_enable,
  output logic monitor_ready
);

  // hold counter is sixteen bits wide
  if (HOLD_CYCLES < 2 || HOLD_CYCLES > 65535) begin : g_hold_range
    $error("hold cycles out of range");
  end

  // ==================================================
  // pin synchronisers
  localparam int NPIN = 6;
  localparam int P_IRQ = 0;
  localparam int P_TEST = 1;
  localparam int P_STRAP0 = 2;
  localparam int P_STRAP1 = 3;
  localparam int P_RESET_N = 4;
  localparam int P_SERIAL = 5;
  localparam logic [5:0] PIN_IDLE = 6'h31;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;
  logic [NPIN-1:0] sync3;
  logic [NPIN-1:0] pin_q;

  assign pin_raw = {monitor_serial_pin_in, reset_pin_n, mode_strap_one, mode_strap_zero,
                    high_test_voltage, irq_pin};

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync1 <= PIN_IDLE;
      sync2 <= PIN_IDLE;
      sync3 <= PIN_IDLE;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pin_q <= PIN_IDLE;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        if (sync2[i] == sync3[i]) begin
          pin_q[i] <= sync3[i];
        end
      end
    end
  end

  // ==================================================
  // register file
  logic [2:0] control;
  logic [7:0] trim;
  logic trim_programmed;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      control <= mmel_pkg::CONTROL_RESET;
      trim <= mmel_pkg::TRIM_RESET;
      trim_programmed <= 1'b0;
    end else if (reg_write) begin
      if (reg_addr == mmel_pkg::REG_CONTROL) begin
        control <= reg_wdata[2:0];
      end
      if (reg_addr == mmel_pkg::REG_TRIM) begin
        trim <= reg_wdata[7:0];
        trim_programmed <= reg_wdata[mmel_pkg::TRIM_PROGRAMMED];
      end
    end
  end

  // ==================================================
  // reset sequencer and mode latch
  mmel_pkg::mmel_rst_state_type rst_state;
  mmel_pkg::mmel_mode_type mode;
  logic [15:0] hold_count;
  logic por_session;
  logic extra_reset;
  logic blank_lo;
  logic blank_hi;
  logic pin_reset_req;
  logic blank_detect;

  assign pin_reset_req = reset_alt_enable && !pin_q[P_RESET_N];
  assign blank_detect = blank_lo && blank_hi;

  function automatic logic is_forced(input mmel_pkg::mmel_mode_type m);
    return m == mmel_pkg::MODE_FORCED_EXT || m == mmel_pkg::MODE_FORCED_INT;
  endfunction

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rst_state <= mmel_pkg::RS_HOLD;
      hold_count <= 16'h0000;
      mode <= mmel_pkg::MODE_USER;
      por_session <= 1'b1;
      extra_reset <= 1'b0;
    end else begin
      unique case (rst_state)
        mmel_pkg::RS_HOLD: begin
          hold_count <= hold_count + 16'h0001;
          if (hold_count == 16'(HOLD_CYCLES - 1)) begin
            hold_count <= 16'h0000;
            rst_state <= mmel_pkg::RS_RUN;
            extra_reset <= 1'b0;
            if (extra_reset) begin
              mode <= pin_q[P_IRQ] ? mmel_pkg::MODE_FORCED_EXT
                                   : mmel_pkg::MODE_FORCED_INT;
            end else if (is_forced(mode)) begin
              mode <= mode;
            end else if (por_session && pin_q[P_TEST] && pin_q[P_STRAP0]
                         && !pin_q[P_STRAP1]) begin
              mode <= mmel_pkg::MODE_NORMAL;
            end else begin
              mode <= mmel_pkg::MODE_USER;
            end
          end
        end
        mmel_pkg::RS_RUN: begin
          if (pin_reset_req) begin
            rst_state <= mmel_pkg::RS_HOLD;
            por_session <= 1'b0;
          end else if (mode == mmel_pkg::MODE_USER && por_session
                       && !pin_q[P_TEST] && blank_detect) begin
            rst_state <= mmel_pkg::RS_HOLD;
            extra_reset <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      blank_lo <= 1'b0;
      blank_hi <= 1'b0;
    end else if (rst_state == mmel_pkg::RS_HOLD) begin
      blank_lo <= 1'b0;
      blank_hi <= 1'b0;
    end else if (vec_fetch_valid) begin
      if (vec_fetch_high) begin
        blank_hi <= vec_fetch_data == mmel_pkg::BLANK_BYTE;
      end else begin
        blank_lo <= vec_fetch_data == mmel_pkg::BLANK_BYTE;
      end
    end
  end

  // ==================================================
  // serial engine
  mmel_link_if link ();
  logic in_monitor;
  logic running;

  assign in_monitor = mode != mmel_pkg::MODE_USER;
  assign running = rst_state == mmel_pkg::RS_RUN;
  assign link.enable = in_monitor && running;
  assign link.bit_period = (mode == mmel_pkg::MODE_FORCED_INT) ? mmel_pkg::BIT_PERIOD_INT
                                                               : mmel_pkg::BIT_PERIOD_EXT;
  assign link.rx_level = pin_q[P_SERIAL];

  mmel_serial_engine u_engine (
    .mclk(mclk),
    .reset(reset),
    .link(link)
  );

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      monitor_serial_pin_out <= 1'b0;
      monitor_serial_pin_oe <= 1'b0;
      monitor_ready <= 1'b0;
    end else begin
      monitor_serial_pin_out <= 1'b0;
      monitor_serial_pin_oe <= link.tx_drive_low;
      monitor_ready <= link.break_sent;
    end
  end

  // ==================================================
  // mode outputs
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      internal_reset <= 1'b1;
      monitor_active <= 1'b0;
      forced_mode <= 1'b0;
      use_internal_osc <= 1'b0;
      apply_trim <= 1'b0;
      oscillator_trim_value <= mmel_pkg::TRIM_RESET;
      vector_page <= mmel_pkg::VECTOR_PAGE_USER;
      porta_bit2_zero <= 1'b0;
    end else begin
      internal_reset <= rst_state == mmel_pkg::RS_HOLD;
      monitor_active <= in_monitor;
      forced_mode <= is_forced(mode);
      use_internal_osc <= mode == mmel_pkg::MODE_FORCED_INT;
      apply_trim <= mode == mmel_pkg::MODE_FORCED_INT && trim_programmed;
      oscillator_trim_value <= trim;
      vector_page <= in_monitor ? mmel_pkg::VECTOR_PAGE_MONITOR
                                : mmel_pkg::VECTOR_PAGE_USER;
      porta_bit2_zero <= in_monitor;
    end
  end

  // watchdog and pin functions
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      watchdog_disable <= 1'b0;
      reset_alt_enable <= 1'b0;
      osc_input_alt_enable <= 1'b0;
      irq_sample_enable <= 1'b0;
    end else begin
      unique case (mode)
        mmel_pkg::MODE_NORMAL: begin
          watchdog_disable <= pin_q[P_TEST];
          reset_alt_enable <= pin_q[P_TEST] || control[mmel_pkg::CTL_RESET_PIN_ENABLE];
          osc_input_alt_enable <= pin_q[P_TEST] || control[mmel_pkg::CTL_OSC_PIN_ENABLE];
          irq_sample_enable <= pin_q[P_TEST] || control[mmel_pkg::CTL_IRQ_ENABLE];
        end
        mmel_pkg::MODE_FORCED_EXT, mmel_pkg::MODE_FORCED_INT: begin
          watchdog_disable <= 1'b1;
          reset_alt_enable <= 1'b0;
          osc_input_alt_enable <= mode == mmel_pkg::MODE_FORCED_EXT;
          irq_sample_enable <= 1'b1;
        end
        default: begin
          watchdog_disable <= 1'b0;
          reset_alt_enable <= control[mmel_pkg::CTL_RESET_PIN_ENABLE];
          osc_input_alt_enable <= control[mmel_pkg::CTL_OSC_PIN_ENABLE];
          irq_sample_enable <= control[mmel_pkg::CTL_IRQ_ENABLE];
        end
      endcase
    end
  end

  // ==================================================
  // register read
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_read) begin
      unique case (reg_addr)
        mmel_pkg::REG_STATUS: begin
          reg_rdata <= {17'h00000, por_session, pin_q[P_TEST], link.break_sent,
                        link.sec_count, 3'h0, rst_state == mmel_pkg::RS_HOLD, mode};
        end
        mmel_pkg::REG_CONTROL: begin
          reg_rdata <= {29'h00000000, control};
        end
        mmel_pkg::REG_TRIM: begin
          reg_rdata <= {23'h000000, trim_programmed, trim};
        end
        default: begin
          reg_rdata <= 32'h00000000;
        end
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

// ===== tb/mmel_monitor_entry_chk.sv
`timescale 1ns/100ps
// ==================================================
// monitor entry checker
module mmel_chk #(parameter int HOLD_CYCLES = 64) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic internal_reset,
  input wire logic high_test_voltage,
  input wire logic monitor_serial_pin_oe,
  input wire logic monitor_active,
  input wire logic forced_mode,
  input wire logic use_internal_osc,
  input wire logic watchdog_disable,
  input wire logic [7:0] vector_page,
  input wire logic reset_alt_enable,
  input wire logic osc_input_alt_enable,
  input wire logic porta_bit2_zero,
  input wire logic irq_sample_enable,
  input wire logic monitor_ready
);
  logic [11:0] oe_len;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ==================================================
  // break length counter
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      oe_len <= 12'h000;
    end else begin
      oe_len <= monitor_serial_pin_oe ? oe_len + 12'h001 : 12'h000;
    end
  end
  sequence tv_normal;
    (monitor_active && !forced_mode && high_test_voltage) [*6];
  endsequence
  // ==================================================
  // assertions
  chk_break_length: assert property (
    $fell(monitor_serial_pin_oe) |-> oe_len == (use_internal_osc ? 12'hd16 : 12'ha00))
    else $error("break length wrong");
  chk_ready_holds: assert property (monitor_ready |=> monitor_ready || internal_reset)
    else $error("ready flag dropped");
  chk_vector_page: assert property (
    vector_page == (monitor_active ? 8'hfe : 8'hff))
    else $error("vector page wrong");
  chk_port_bit: assert property (monitor_active |-> porta_bit2_zero)
    else $error("port bit not forced low");
  chk_forced_wdog: assert property (forced_mode |-> watchdog_disable)
    else $error("watchdog on in forced mode");
  chk_forced_irq: assert property (forced_mode |-> irq_sample_enable)
    else $error("irq sampling off in forced mode");
  chk_forced_pins: assert property (forced_mode |-> !reset_alt_enable &&
    osc_input_alt_enable == !use_internal_osc)
    else $error("forced pin functions wrong");
  chk_normal_wdog: assert property (tv_normal |-> watchdog_disable)
    else $error("watchdog on under test voltage");
  chk_normal_alt: assert property (
    tv_normal |-> reset_alt_enable && osc_input_alt_enable)
    else $error("alternate pins off under test voltage");
endmodule

// ===== tb/mmel_host_model.sv
`timescale 1ns/100ps
// ==================================================
// host side of the serial wire
module mmel_host_model (
  input wire logic mclk,
  input wire logic dev_oe,
  output logic wire_level
);
  logic host_low = 1'b0;
  assign wire_level = !(dev_oe || host_low);
  task automatic send_byte(input logic [7:0] data, input int period);
    logic [9:0] frame;
    frame = {1'b1, data, 1'b0};
    for (int b = 0; b < 10; b++) begin
      host_low <= !frame[b];
      repeat (period) @(posedge mclk);
    end
  endtask
  task automatic send_bytes(input int n, input int period, input int gap);
    @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      send_byte(8'h5a ^ 8'(i), period);
      repeat (gap) @(posedge mclk);
    end
  endtask
endmodule

// ===== tb/testbench.sv
`timescale 1ns/100ps
// ==================================================
// monitor entry testbench
module testbench;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0, reg_read = 1'b0, irq_pin = 1'b1, high_test_voltage = 1'b0;
  logic mode_strap_zero = 1'b0, mode_strap_one = 1'b0, reset_pin_n = 1'b1;
  logic vec_fetch_valid = 1'b0, vec_fetch_high = 1'b0;
  logic [7:0] vec_fetch_data = 8'h00;
  logic [31:0] reg_rdata;
  logic [7:0] vector_page, trim_out;
  logic wire_level, ser_out, ser_oe, internal_reset, monitor_active, forced_mode;
  logic use_internal_osc, apply_trim, watchdog_disable, reset_alt_enable;
  logic osc_input_alt_enable, porta_bit2_zero, irq_sample_enable, monitor_ready;
  logic [2:0] watch;
  int err_total = 0, samples_checked = 0, oe_run = 0, brk_len = 0;
  assign watch = {monitor_ready, ser_oe, internal_reset};
  always #5 mclk = ~mclk;
  mmel_monitor_entry #(.HOLD_CYCLES(8)) i_mmel_monitor_entry (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq_pin(irq_pin),
    .high_test_voltage(high_test_voltage), .mode_strap_zero(mode_strap_zero),
    .mode_strap_one(mode_strap_one), .reset_pin_n(reset_pin_n),
    .monitor_serial_pin_in(wire_level), .vec_fetch_valid(vec_fetch_valid),
    .vec_fetch_high(vec_fetch_high), .vec_fetch_data(vec_fetch_data),
    .monitor_serial_pin_out(ser_out), .monitor_serial_pin_oe(ser_oe),
    .internal_reset(internal_reset), .monitor_active(monitor_active),
    .forced_mode(forced_mode), .use_internal_osc(use_internal_osc), .apply_trim(apply_trim),
    .oscillator_trim_value(trim_out), .watchdog_disable(watchdog_disable),
    .vector_page(vector_page), .reset_alt_enable(reset_alt_enable),
    .osc_input_alt_enable(osc_input_alt_enable), .porta_bit2_zero(porta_bit2_zero),
    .irq_sample_enable(irq_sample_enable), .monitor_ready(monitor_ready));
  mmel_host_model i_mmel_host_model (.mclk(mclk), .dev_oe(ser_oe), .wire_level(wire_level));
  // ==================================================
  // break length seen on the wire
  always @(posedge mclk) begin
    if (ser_oe === 1'b1) begin
      oe_run <= oe_run + 1;
    end else if (oe_run != 0) begin
      brk_len <= oe_run;
      oe_run <= 0;
    end
  end
  // ==================================================
  // tasks
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wait_for(input int sel, input logic lvl, input int lim);
    int n;
    n = 0;
    while (watch[sel] !== lvl) begin
      if (n >= lim) begin
        err_total++;
        $display("[FAIL] %0t wait ran out", $time);
        wrap_up();
      end else begin
        n++;
        @(posedge mclk);
        #1;
      end
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    chk_word(reg_rdata & m, e);
  endtask
  task automatic vfetch(input logic hi, input logic [7:0] d);
    @(posedge mclk);
    vec_fetch_valid <= 1'b1;
    vec_fetch_high <= hi;
    vec_fetch_data <= d;
    @(posedge mclk);
    vec_fetch_valid <= 1'b0;
    #1;
  endtask
  task automatic power_up(input logic tv, s0, s1, irq);
    @(posedge mclk);
    reset <= 1'b1;
    high_test_voltage <= tv;
    mode_strap_zero <= s0;
    mode_strap_one <= s1;
    irq_pin <= irq;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    wait_for(0, 1'b0, 40);
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic expect_mode(input logic mon, frc, wd, osc);
    chk_bit(monitor_active, mon);
    chk_bit(forced_mode, frc);
    chk_bit(watchdog_disable, wd);
    chk_bit(use_internal_osc, osc);
    chk_word({24'h0, vector_page}, mon ? 32'hfe : 32'hff);
    chk_bit(porta_bit2_zero, mon);
  endtask
  task automatic do_break(input int period, input int gap);
    i_mmel_host_model.send_bytes(7, period, gap);
    #1;
    chk_bit(ser_oe, 1'b0);
    chk_bit(wire_level, 1'b1);
    chk_bit(ser_out, 1'b0);
    i_mmel_host_model.send_bytes(1, period, gap);
    wait_for(2, 1'b1, 12 * period);
    repeat (2) @(posedge mclk);
    #1;
    chk_word(brk_len, 10 * period);
  endtask
  // ==================================================
  // scenarios
  initial begin
    power_up(1'b0, 1'b0, 1'b0, 1'b1);
    expect_mode(1'b0, 1'b0, 1'b0, 1'b0);
    chk_word({24'h0, trim_out}, {24'h0, mmel_pkg::TRIM_RESET});
    reg_rd(mmel_pkg::REG_CONTROL, 32'h7, 32'h0);
    reg_wr(4'hc, 32'hffffffff);
    reg_rd(4'hc, 32'hffffffff, 32'h0);
    power_up(1'b1, 1'b1, 1'b1, 1'b1);
    expect_mode(1'b0, 1'b0, 1'b0, 1'b0);
    power_up(1'b1, 1'b1, 1'b0, 1'b1);
    expect_mode(1'b1, 1'b0, 1'b1, 1'b0);
    @(posedge mclk);
    mode_strap_zero <= 1'b0;
    mode_strap_one <= 1'b1;
    do_break(256, 0);
    chk_bit(monitor_active, 1'b1);
    @(posedge mclk);
    high_test_voltage <= 1'b0;
    reg_wr(mmel_pkg::REG_CONTROL, 32'h1);
    repeat (8) @(posedge mclk);
    #1;
    chk_bit(watchdog_disable, 1'b0);
    chk_bit(irq_sample_enable, 1'b1);
    chk_bit(reset_alt_enable, 1'b0);
    reg_wr(mmel_pkg::REG_CONTROL, 32'h6);
    repeat (2) @(posedge mclk);
    #1;
    chk_bit(irq_sample_enable, 1'b0);
    chk_bit(osc_input_alt_enable, 1'b1);
    chk_bit(monitor_active, 1'b1);
    @(posedge mclk);
    reset_pin_n <= 1'b0;
    wait_for(0, 1'b1, 20);
    @(posedge mclk);
    reset_pin_n <= 1'b1;
    wait_for(0, 1'b0, 40);
    expect_mode(1'b0, 1'b0, 1'b0, 1'b0);
    power_up(1'b0, 1'b0, 1'b0, 1'b0);
    vfetch(1'b0, 8'hff);
    vfetch(1'b1, 8'hff);
    wait_for(0, 1'b1, 10);
    wait_for(0, 1'b0, 40);
    expect_mode(1'b1, 1'b1, 1'b1, 1'b1);
    chk_bit(irq_sample_enable, 1'b1);
    chk_bit(osc_input_alt_enable, 1'b0);
    reg_rd(mmel_pkg::REG_STATUS, 32'h1f, 32'h8);
    chk_bit(apply_trim, 1'b0);
    reg_wr(mmel_pkg::REG_TRIM, 32'h1a5);
    repeat (2) @(posedge mclk);
    #1;
    chk_bit(apply_trim, 1'b1);
    chk_word({24'h0, trim_out}, 32'ha5);
    do_break(335, 50);
    @(posedge mclk);
    reset_pin_n <= 1'b0;
    repeat (20) @(posedge mclk);
    reset_pin_n <= 1'b1;
    repeat (20) @(posedge mclk);
    #1;
    expect_mode(1'b1, 1'b1, 1'b1, 1'b1);
    power_up(1'b0, 1'b0, 1'b1, 1'b1);
    vfetch(1'b0, 8'hff);
    vfetch(1'b1, 8'hff);
    wait_for(0, 1'b1, 10);
    wait_for(0, 1'b0, 40);
    expect_mode(1'b1, 1'b1, 1'b1, 1'b0);
    chk_bit(osc_input_alt_enable, 1'b1);
    power_up(1'b0, 1'b1, 1'b0, 1'b0);
    vfetch(1'b0, 8'hff);
    vfetch(1'b1, 8'h12);
    repeat (20) @(posedge mclk);
    #1;
    chk_bit(internal_reset, 1'b0);
    expect_mode(1'b0, 1'b0, 1'b0, 1'b0);
    wrap_up();
  end
endmodule

bind mmel_monitor_entry mmel_chk #(.HOLD_CYCLES(HOLD_CYCLES)) i_mmel_chk (
  .mclk(mclk), .reset(reset), .high_test_voltage(high_test_voltage),
  .internal_reset(internal_reset),
  .monitor_serial_pin_oe(monitor_serial_pin_oe), .monitor_active(monitor_active),
  .forced_mode(forced_mode), .use_internal_osc(use_internal_osc),
  .watchdog_disable(watchdog_disable), .vector_page(vector_page),
  .reset_alt_enable(reset_alt_enable), .osc_input_alt_enable(osc_input_alt_enable),
  .porta_bit2_zero(porta_bit2_zero), .irq_sample_enable(irq_sample_enable),
  .monitor_ready(monitor_ready));
